// File: inc/ldr_pkg.sv
/*
 * ldr_pkg: constants and carriers for the logical-device irq and dma
 * routing block. Assumes an 8-bit configuration index per function and
 * a 12-bit qualified host i/o address.
 */
package ldr_pkg;
   localparam int         NUM_FN         = 4;
   localparam int         FN_FLOPPY      = 0;
   localparam int         FN_PARALLEL    = 1;
   localparam int         FN_UART1       = 2;
   localparam int         FN_UART2       = 3;
   localparam logic [3:0] DMA_CAPABLE    = 4'b1011;

   // configuration indices, per function; IDX_MODE is one register shared by all
   localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
   localparam logic [7:0] IDX_BASE_HI    = 8'h60;
   localparam logic [7:0] IDX_BASE_LO    = 8'h61;
   localparam logic [7:0] IDX_BASE2_HI   = 8'h62;
   localparam logic [7:0] IDX_BASE2_LO   = 8'h63;
   localparam logic [7:0] IDX_IRQ_SEL    = 8'h70;
   localparam logic [7:0] IDX_DMA_SEL    = 8'h74;
   localparam logic [7:0] IDX_MODE       = 8'hF8;
   localparam logic [7:0] IDX_STATUS     = 8'hF9;
   localparam logic [7:0] IDX_POWER      = 8'hFA;

   // reset values
   localparam logic       RST_ACTIVE     = 1'b0;
   localparam logic [15:0] RST_BASE      = 16'h0000;
   localparam logic [7:0] RST_IRQ_SEL    = 8'h00;
   localparam logic [7:0] RST_DMA_SEL    = 8'h04;
   localparam logic [7:0] RST_MODE       = 8'h00;

   // field positions
   localparam int         ACT_BIT        = 0;
   localparam int         MODE_SERIAL_BIT = 0;
   localparam int         MODE_SMI_BIT   = 1;

   // address windows
   localparam logic [11:0] BASE_MIN      = 12'h100;
   localparam logic [11:0] BASE_MAX8     = 12'hFF8;
   localparam logic [11:0] BASE_MAX4     = 12'hFFC;
   localparam logic [11:0] WIN8_MASK     = 12'h007;
   localparam logic [11:0] WIN4_MASK     = 12'h003;
   localparam logic [12:0] ECP_EXT_OFS   = 13'h0400;
   localparam logic [11:0] ECP_EXT_SPAN  = 12'h003;
   localparam logic [11:0] KBD_DATA_PORT = 12'h060;
   localparam logic [11:0] KBD_CMD_PORT  = 12'h064;

   // irq levels
   localparam logic [3:0] IRQ_LVL_SHARED_SMI = 4'h2;
   localparam logic [15:0] PAR_IRQ_LEVELS    = 16'h1CF8;

   // ecr modes whose irq ignores the control-port gate
   localparam logic [2:0] ECR_FIFO       = 3'b010;
   localparam logic [2:0] ECR_ECP        = 3'b011;
   localparam logic [2:0] ECR_TEST       = 3'b110;

   // function-local gate bits, driven by the functions themselves
   typedef struct packed {
      logic       floppyDmaGate;
      logic       floppyPowerDown;
      logic       parallelIrqGate;
      logic       parEcpMode;
      logic [2:0] ecrMode;
      logic       ecpServiceFlag;
      logic       ecpDmaGate;
      logic [3:0] uart1IrqEnable;
      logic       uart1AuxOutGate;
      logic [3:0] uart2IrqEnable;
      logic       uart2AuxOutGate;
      logic       uart2DmaEnable;
   } ldr_local_t;

   // decoded chip selects towards the functions
   typedef struct packed {
      logic floppy;
      logic parLow;
      logic parExt;
      logic uart1;
      logic uart2;
      logic fastIr;
      logic kbdData;
      logic kbdCmd;
   } ldr_sel_t;
endpackage : ldr_pkg

// File: logic/ldr_routing.sv
/*
 * ldr_routing: base address decode and irq/dma pin routing for four
 * relocatable functions plus the fixed keyboard ports.
 * Assumes isa address, strobes and dma acknowledges arrive from pins;
 * function gate bits and requests come from logic on clk_sys.
 */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// - compare host addresses on address bits 11 to 0 only.
// - parallel base on 4-byte steps to 0xFFC, or 8-byte; ext regs at +400h..+402h.
// - keyboard fixed at ports 60 and 64, no base register.
// - second serial decodes extra 8-byte fast infrared window from 0x62/0x63.
// - irq active only with non-zero level and function enables met.
// - floppy irq and dack float, requests ignored, when gate clear or powered down.
// - ECP mode parallel irq also needs service flag cleared.
// - serial irq needs any of enable bits 0-3 and aux output gate.
// - serial irq floats while aux output gate is zero.
// - irq pins selected by no active function are tri-stated.
// - level 2 usable only while system management irq output disabled.
// - serial irq mode allows all levels; pin mode only 3-7 and 10-12.
// - dma field 1..3 are channels; 0 reserved; 4..7 no channel.
// - dma channel active only with valid select and function dma enable.
// - dma request pins selected by no active function are tri-stated.
// - local disables add to inactive or invalid-base disables.
// - SPP/EPP parallel irq floats while control-port irq gate is zero.
// - ECP dma always gated; irq gated except modes 010, 011, 110.
// - activate and power bits are one linked bit.
// - accesses ignored when base lies outside the permitted range.
// - irq select resets to zero; irqs are active-high edges.
module ldr_routing (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [9:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   input  wire logic              regWrStb,
   input  wire logic              regRdStb,
   output logic [7:0]             regRdData,
   input  wire logic [11:0]       isaAddr,
   input  wire logic              isaIorN,
   input  wire logic              isaIowN,
   input  wire logic [3:0]        isaDackN,
   input  wire ldr_pkg::ldr_local_t fnLocal,
   input  wire logic [3:0]        fnIrqReq,
   input  wire logic [3:0]        fnDrqReq,
   output logic [3:0]             fnActive,
   output logic [3:0]             fnDack,
   output ldr_pkg::ldr_sel_t      fnSel,
   output logic [15:0]            irqOut,
   output logic [15:0]            irqOe,
   output logic [3:0]             drqOut,
   output logic [3:0]             drqOe
);
   import ldr_pkg::*;

   function automatic logic inWin(input logic [11:0] a, input logic [11:0] b,
                                  input logic [11:0] m);
      inWin = ((a & ~m) == (b & ~m));
   endfunction : inWin

   function automatic logic base8Ok(input logic [15:0] b);
      base8Ok = (b[15:12] == 4'h0) && (b[11:0] >= BASE_MIN) && (b[11:0] <= BASE_MAX8)
                && ((b[11:0] & WIN8_MASK) == 12'h000);
   endfunction : base8Ok

   function automatic logic levelOk(input logic [3:0] l, input logic serialMode,
                                    input logic smiOn);
      levelOk = (l != 4'h0) && !((l == IRQ_LVL_SHARED_SMI) && smiOn)
                && (serialMode || PAR_IRQ_LEVELS[l]);
   endfunction : levelOk

   logic [3:0]  act_q;
   logic [15:0] base_q [NUM_FN];
   logic [15:0] base2_q;
   logic [7:0]  irqSel_q [NUM_FN];
   logic [7:0]  dmaSel_q [NUM_FN];
   logic [7:0]  mode_q;
   logic [7:0]  rdData_q;
   logic [11:0] addrMeta_q, addrSync_q;
   logic [1:0]  strbMeta_q, strbSync_q;
   logic [3:0]  dackMeta_q, dackSync_q;
   ldr_sel_t    sel_d, sel_q;
   logic [3:0]  irqEn, floppy_dma_gate, baseOk;
   logic [3:0]  irqGrant_d, irqGrant_q, dmaGrant_d, dmaGrant_q;
   logic [15:0] irqOut_d, irqOe_d, irqOut_q, irqOe_q;
   logic [3:0]  drqOut_d, drqOe_d, drqOut_q, drqOe_q, dack_d, dack_q;
   logic        parAlign8, ecpIrqOn;
   logic [12:0] extBase;
   logic [11:0] extDiff;
   logic [1:0]  wrFn;
   logic [7:0]  wrIdx;

   assign wrFn  = regAddr[9:8];
   assign wrIdx = regAddr[7:0];

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         act_q   <= {NUM_FN{RST_ACTIVE}};
         base2_q <= RST_BASE;
         mode_q  <= RST_MODE;
         for (int f = 0; f < NUM_FN; f++) begin
            base_q[f]   <= RST_BASE;
            irqSel_q[f] <= RST_IRQ_SEL;
            dmaSel_q[f] <= RST_DMA_SEL;
         end
      end else if (regWrStb) begin
         case (wrIdx)
            IDX_ACTIVATE, IDX_POWER: begin
               act_q[wrFn] <= regWrData[ACT_BIT];
            end
            IDX_BASE_HI: begin
               base_q[wrFn][15:8] <= regWrData;
            end
            IDX_BASE_LO: begin
               base_q[wrFn][7:0] <= regWrData;
            end
            IDX_BASE2_HI: begin
               if (wrFn == 2'(FN_UART2)) base2_q[15:8] <= regWrData;
            end
            IDX_BASE2_LO: begin
               if (wrFn == 2'(FN_UART2)) base2_q[7:0] <= regWrData;
            end
            IDX_IRQ_SEL: begin
               irqSel_q[wrFn] <= regWrData;
            end
            IDX_DMA_SEL: begin
               if (DMA_CAPABLE[wrFn]) dmaSel_q[wrFn] <= regWrData;
            end
            IDX_MODE: begin
               mode_q <= regWrData;
            end
            default: begin
            end
         endcase
      end
   end

   // read port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_q <= 8'h00;
      end else if (!regRdStb) begin
         rdData_q <= 8'h00;
      end else begin
         case (wrIdx)
            IDX_ACTIVATE, IDX_POWER: rdData_q <= {7'h00, act_q[wrFn]};
            IDX_BASE_HI:  rdData_q <= base_q[wrFn][15:8];
            IDX_BASE_LO:  rdData_q <= base_q[wrFn][7:0];
            IDX_BASE2_HI: rdData_q <= (wrFn == 2'(FN_UART2)) ? base2_q[15:8] : 8'h00;
            IDX_BASE2_LO: rdData_q <= (wrFn == 2'(FN_UART2)) ? base2_q[7:0] : 8'h00;
            IDX_IRQ_SEL:  rdData_q <= irqSel_q[wrFn];
            IDX_DMA_SEL:  rdData_q <= DMA_CAPABLE[wrFn] ? dmaSel_q[wrFn] : 8'h00;
            IDX_MODE:     rdData_q <= mode_q;
            IDX_STATUS:   rdData_q <= {dmaGrant_q, irqGrant_q};
            default:      rdData_q <= 8'h00;
         endcase
      end
   end

   // pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addrMeta_q <= 12'h000;
         addrSync_q <= 12'h000;
         strbMeta_q <= 2'b00;
         strbSync_q <= 2'b00;
         dackMeta_q <= 4'hF;
         dackSync_q <= 4'hF;
      end else begin
         addrMeta_q <= isaAddr;
         addrSync_q <= addrMeta_q;
         strbMeta_q <= {~isaIowN, ~isaIorN};
         strbSync_q <= strbMeta_q;
         dackMeta_q <= isaDackN;
         dackSync_q <= dackMeta_q;
      end
   end

   // base validity and window decode
   always_comb begin
      baseOk[FN_FLOPPY]   = base8Ok(base_q[FN_FLOPPY]);
      baseOk[FN_UART1]    = base8Ok(base_q[FN_UART1]);
      baseOk[FN_UART2]    = base8Ok(base_q[FN_UART2]);
      baseOk[FN_PARALLEL] = (base_q[FN_PARALLEL][15:12] == 4'h0)
                            && (base_q[FN_PARALLEL][11:0] >= BASE_MIN)
                            && (base_q[FN_PARALLEL][11:0] <= BASE_MAX4)
                            && ((base_q[FN_PARALLEL][11:0] & WIN4_MASK) == 12'h000);
      parAlign8 = ((base_q[FN_PARALLEL][11:0] & WIN8_MASK) == 12'h000);
      extBase   = {1'b0, base_q[FN_PARALLEL][11:0]} + ECP_EXT_OFS;
      extDiff   = addrSync_q - extBase[11:0];
      sel_d = '0;
      if (strbSync_q != 2'b00) begin
         sel_d.floppy = act_q[FN_FLOPPY] && baseOk[FN_FLOPPY]
                        && inWin(addrSync_q, base_q[FN_FLOPPY][11:0], WIN8_MASK);
         sel_d.uart1  = act_q[FN_UART1] && baseOk[FN_UART1]
                        && inWin(addrSync_q, base_q[FN_UART1][11:0], WIN8_MASK);
         sel_d.uart2  = act_q[FN_UART2] && baseOk[FN_UART2]
                        && inWin(addrSync_q, base_q[FN_UART2][11:0], WIN8_MASK);
         sel_d.fastIr = act_q[FN_UART2] && base8Ok(base2_q)
                        && inWin(addrSync_q, base2_q[11:0], WIN8_MASK);
         sel_d.parLow = act_q[FN_PARALLEL] && baseOk[FN_PARALLEL]
                        && inWin(addrSync_q, base_q[FN_PARALLEL][11:0],
                                 parAlign8 ? WIN8_MASK : WIN4_MASK);
         sel_d.parExt = act_q[FN_PARALLEL] && baseOk[FN_PARALLEL] && !extBase[12]
                        && (extDiff < ECP_EXT_SPAN);
         sel_d.kbdData = (addrSync_q == KBD_DATA_PORT);
         sel_d.kbdCmd  = (addrSync_q == KBD_CMD_PORT);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_q <= '0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // function-local gates on top of activate and base checks
   always_comb begin
      ecpIrqOn = (fnLocal.ecrMode == ECR_FIFO) || (fnLocal.ecrMode == ECR_ECP)
                 || (fnLocal.ecrMode == ECR_TEST);
      irqEn[FN_FLOPPY]   = fnLocal.floppyDmaGate && !fnLocal.floppyPowerDown;
      irqEn[FN_PARALLEL] = fnLocal.parEcpMode
                           ? (!fnLocal.ecpServiceFlag
                              && (ecpIrqOn || fnLocal.parallelIrqGate))
                           : fnLocal.parallelIrqGate;
      irqEn[FN_UART1] = (|fnLocal.uart1IrqEnable) && fnLocal.uart1AuxOutGate;
      irqEn[FN_UART2] = (|fnLocal.uart2IrqEnable) && fnLocal.uart2AuxOutGate;
      floppy_dma_gate[FN_FLOPPY]   = fnLocal.floppyDmaGate && !fnLocal.floppyPowerDown;
      floppy_dma_gate[FN_PARALLEL] = fnLocal.parEcpMode && fnLocal.ecpDmaGate;
      floppy_dma_gate[FN_UART1]    = 1'b0;
      floppy_dma_gate[FN_UART2]    = fnLocal.uart2DmaEnable;
      irqEn = irqEn & act_q & baseOk;
      floppy_dma_gate = floppy_dma_gate & act_q & baseOk & DMA_CAPABLE;
   end

   // pin arbitration: lowest function number wins a shared level
   always_comb begin
      irqOut_d   = '0;
      irqOe_d    = '0;
      irqGrant_d = '0;
      drqOut_d   = '0;
      drqOe_d    = '0;
      dmaGrant_d = '0;
      dack_d     = '0;
      for (int f = 0; f < NUM_FN; f++) begin
         if (irqEn[f] && levelOk(irqSel_q[f][3:0], mode_q[MODE_SERIAL_BIT],
                                 mode_q[MODE_SMI_BIT])
             && !irqOe_d[irqSel_q[f][3:0]]) begin
            irqOe_d[irqSel_q[f][3:0]]  = 1'b1;
            irqOut_d[irqSel_q[f][3:0]] = fnIrqReq[f];
            irqGrant_d[f]              = 1'b1;
         end
         if (floppy_dma_gate[f] && (dmaSel_q[f][2:0] != 3'h0) && !dmaSel_q[f][2]
             && !drqOe_d[dmaSel_q[f][1:0]]) begin
            drqOe_d[dmaSel_q[f][1:0]]  = 1'b1;
            drqOut_d[dmaSel_q[f][1:0]] = fnDrqReq[f];
            dmaGrant_d[f]              = 1'b1;
            dack_d[f]                  = !dackSync_q[dmaSel_q[f][1:0]];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irqOut_q   <= '0;
         irqOe_q    <= '0;
         irqGrant_q <= '0;
         drqOut_q   <= '0;
         drqOe_q    <= '0;
         dmaGrant_q <= '0;
         dack_q     <= '0;
      end else begin
         irqOut_q   <= irqOut_d;
         irqOe_q    <= irqOe_d;
         irqGrant_q <= irqGrant_d;
         drqOut_q   <= drqOut_d;
         drqOe_q    <= drqOe_d;
         dmaGrant_q <= dmaGrant_d;
         dack_q     <= dack_d;
      end
   end

   assign regRdData = rdData_q;
   assign fnActive  = act_q;
   assign fnSel     = sel_q;
   assign irqOut    = irqOut_q;
   assign irqOe     = irqOe_q;
   assign drqOut    = drqOut_q;
   assign drqOe     = drqOe_q;
   assign fnDack    = dack_q;

   sequence s_kbdRead;
      (strbSync_q != 2'b00) && (addrSync_q == KBD_DATA_PORT);
   endsequence

   property p_kbdFixed;
      @(posedge clk_sys) disable iff (rst) s_kbdRead |=> fnSel.kbdData;
   endproperty
   a_kbdFixed: assert property (p_kbdFixed)
      else $error("keyboard data port not decoded");

   property p_dmaReset;
      @(posedge clk_sys) rst |=> (dmaSel_q[FN_FLOPPY] == RST_DMA_SEL) && (drqOe == 4'h0);
   endproperty
   a_dmaReset: assert property (p_dmaReset)
      else $error("dma select not at reset value");

   property p_irqReset;
      @(posedge clk_sys) rst |=> (irqSel_q[FN_UART1] == RST_IRQ_SEL) && (irqOe == 16'h0000);
   endproperty
   a_irqReset: assert property (p_irqReset)
      else $error("irq select not zero after reset");

   property p_floppyFloat;
      @(posedge clk_sys) disable iff (rst)
         (!fnLocal.floppyDmaGate || fnLocal.floppyPowerDown)
         |=> !irqGrant_q[FN_FLOPPY] && !dmaGrant_q[FN_FLOPPY] && !fnDack[FN_FLOPPY];
   endproperty
   a_floppyFloat: assert property (p_floppyFloat)
      else $error("floppy drives irq or dack while gated");

   property p_uartAux;
      @(posedge clk_sys) disable iff (rst)
         !fnLocal.uart1AuxOutGate |=> !irqGrant_q[FN_UART1];
   endproperty
   a_uartAux: assert property (p_uartAux)
      else $error("serial irq driven with aux gate low");

   property p_uartEnable;
      @(posedge clk_sys) disable iff (rst)
         irqGrant_q[FN_UART2] |-> ($past(fnLocal.uart2IrqEnable) != 4'h0);
   endproperty
   a_uartEnable: assert property (p_uartEnable)
      else $error("serial irq granted with no enable bit");

   property p_ecpService;
      @(posedge clk_sys) disable iff (rst)
         fnLocal.parEcpMode && fnLocal.ecpServiceFlag |=> !irqGrant_q[FN_PARALLEL];
   endproperty
   a_ecpService: assert property (p_ecpService)
      else $error("parallel irq driven with service flag set");

   property p_sppGate;
      @(posedge clk_sys) disable iff (rst)
         !fnLocal.parEcpMode && !fnLocal.parallelIrqGate |=> !irqGrant_q[FN_PARALLEL];
   endproperty
   a_sppGate: assert property (p_sppGate)
      else $error("parallel irq driven with control gate low");

   property p_smiLevel;
      @(posedge clk_sys) disable iff (rst)
         mode_q[MODE_SMI_BIT] |=> !irqOe[IRQ_LVL_SHARED_SMI];
   endproperty
   a_smiLevel: assert property (p_smiLevel)
      else $error("level 2 driven while smi enabled");

   property p_pinLevels;
      @(posedge clk_sys) disable iff (rst)
         !mode_q[MODE_SERIAL_BIT] |=> ((irqOe & ~PAR_IRQ_LEVELS) == 16'h0000);
   endproperty
   a_pinLevels: assert property (p_pinLevels)
      else $error("unavailable level driven in pin mode");

   property p_unusedFloat;
      @(posedge clk_sys) disable iff (rst)
         ($countones(irqOe) == $countones(irqGrant_q))
         && ($countones(drqOe) == $countones(dmaGrant_q)) && !drqOe[0];
   endproperty
   a_unusedFloat: assert property (p_unusedFloat)
      else $error("pin driven without a single owner");

   property p_readLatency;
      @(posedge clk_sys) disable iff (rst)
         regRdStb && (wrIdx == IDX_DMA_SEL) && (wrFn == 2'(FN_FLOPPY))
         |=> regRdData == $past(dmaSel_q[FN_FLOPPY]);
   endproperty
   a_readLatency: assert property (p_readLatency)
      else $error("dma select read back wrong");
endmodule : ldr_routing

// File: sim/ldr_host_model.sv
/*
 * ldr_host_model: isa host cycles and a dma controller facing the routing block.
 * Assumes the bench requests host cycles on clk_sys and sets the dack delay.
 */
`timescale 1ns/1ps
module ldr_host_model (
   input  wire logic        clk_sys,
   input  wire logic        hostReq,
   input  wire logic        hostRd,
   input  wire logic [11:0] hostAddr,
   input  wire logic [1:0]  dackDelay,
   input  wire logic [3:0]  drqOut,
   input  wire logic [3:0]  drqOe,
   output logic [11:0]      isaAddr,
   output logic             isaIorN,
   output logic             isaIowN,
   output logic [3:0]       isaDackN
);
   logic [1:0] waitQ [4] = '{2'd0, 2'd0, 2'd0, 2'd0};
   initial begin
      isaAddr = 12'h000;
      isaIorN = 1'b1;
      isaIowN = 1'b1;
      isaDackN = 4'hF;
   end
   always @(posedge clk_sys) begin
      // released address lines keep changing
      isaAddr <= hostReq ? hostAddr : ~isaAddr;
      isaIorN <= !(hostReq && hostRd);
      isaIowN <= !(hostReq && !hostRd);
      for (int c = 0; c < 4; c++) begin
         if (drqOe[c] && drqOut[c]) begin
            if (waitQ[c] == dackDelay) isaDackN[c] <= 1'b0;
            else waitQ[c] <= waitQ[c] + 2'd1;
         end else begin
            waitQ[c] <= 2'd0;
            isaDackN[c] <= 1'b1;
         end
      end
   end
endmodule : ldr_host_model

// File: sim/logical_device_irq_dma_routing_tb_top.sv
/*
 * Bench for ldr_routing: config registers, decode, irq and dma routing.
 * Assumes the design's latencies as handed over; host side is ldr_host_model.
 */
`timescale 1ns/1ps
module logical_device_irq_dma_routing_tb_top;
   import ldr_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [9:0] regAddr = '0;
   logic [7:0] regWrData = '0, regRdData;
   logic [11:0] isaAddr, hostAddr = '0;
   logic isaIorN, isaIowN, hostReq = 1'b0, hostRd = 1'b0, e, act;
   logic [3:0] isaDackN, fnIrqReq = 4'hF, fnDrqReq = 4'hF, fnActive, fnDack, drqOut, drqOe, lv;
   logic [15:0] irqOut, irqOe;
   logic [1:0] dackDelay = '0, md;
   logic [2:0] ds;
   logic [31:0] seed = 32'h0001_24DD, r;
   ldr_local_t fnLocal = '0, loc;
   ldr_sel_t fnSel;
   int fail_count = 0, check_count = 0, cyc = 0, f;
   logic [35:0] decT [13] = '{36'hF_0000_6002, 36'hF_0000_6401, 36'hF_0003_F280,
      36'hF_0003_7F40, 36'hF_0007_7A20, 36'hF_0003_FF10, 36'hF_0002_F808, 36'hF_0002_8304,
      36'hF_0005_0000, 36'h0_0F00_F200, 36'h1_27C2_7F40, 36'hF_0002_8004, 36'h0_3F03_F280};
   always #12.5 clk_sys = ~clk_sys;
   ldr_routing dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .isaAddr(isaAddr),
      .isaIorN(isaIorN), .isaIowN(isaIowN), .isaDackN(isaDackN), .fnLocal(fnLocal),
      .fnIrqReq(fnIrqReq), .fnDrqReq(fnDrqReq), .fnActive(fnActive), .fnDack(fnDack),
      .fnSel(fnSel), .irqOut(irqOut), .irqOe(irqOe), .drqOut(drqOut), .drqOe(drqOe));
   ldr_host_model host_u (.clk_sys(clk_sys), .hostReq(hostReq), .hostRd(hostRd),
      .hostAddr(hostAddr), .dackDelay(dackDelay), .drqOut(drqOut), .drqOe(drqOe),
      .isaAddr(isaAddr), .isaIorN(isaIorN), .isaIowN(isaIowN), .isaDackN(isaDackN));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic lvl_ok(logic [3:0] l, logic [1:0] m);
      if (l == 4'h0 || (l == IRQ_LVL_SHARED_SMI && m[MODE_SMI_BIT])) return 1'b0;
      return m[MODE_SERIAL_BIT] ? 1'b1 : PAR_IRQ_LEVELS[l];
   endfunction : lvl_ok
   function automatic logic irq_en(int g, ldr_local_t l);
      case (g)
         FN_FLOPPY: return l.floppyDmaGate && !l.floppyPowerDown;
         FN_PARALLEL: return l.parEcpMode ? !l.ecpServiceFlag && (l.parallelIrqGate
            || l.ecrMode inside {ECR_FIFO, ECR_ECP, ECR_TEST}) : l.parallelIrqGate;
         FN_UART1: return (|l.uart1IrqEnable) && l.uart1AuxOutGate;
         default: return (|l.uart2IrqEnable) && l.uart2AuxOutGate;
      endcase
   endfunction : irq_en
   function automatic logic drq_en(int g, ldr_local_t l);
      case (g)
         FN_FLOPPY: return l.floppyDmaGate && !l.floppyPowerDown;
         FN_PARALLEL: return l.parEcpMode && l.ecpDmaGate;
         FN_UART2: return l.uart2DmaEnable;
         default: return 1'b0;
      endcase
   endfunction : drq_en
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input int g, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= {g[1:0], idx};
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rd(input int g, input logic [7:0] idx, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= {g[1:0], idx};
      regRdStb <= 1'b1;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      #1 chk("regRdData", {8'h0, regRdData}, {8'h0, exp});
   endtask : rd
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(0, IDX_DMA_SEL, RST_DMA_SEL);
      rd(1, IDX_IRQ_SEL, RST_IRQ_SEL);
      rd(2, IDX_DMA_SEL, 8'h00);
      wr(0, 8'h31, 8'hFF);
      rd(0, 8'h31, 8'h00);
      wr(3, IDX_DMA_SEL, 8'h02);
      rd(3, IDX_DMA_SEL, 8'h02);
      wr(1, IDX_POWER, 8'h01);
      rd(1, IDX_ACTIVATE, 8'h01);
      chk("fnActive", {12'h0, fnActive}, 16'h0002);
      wr(0, IDX_BASE_HI, 8'h03);
      wr(0, IDX_BASE_LO, 8'hF0);
      wr(1, IDX_BASE_HI, 8'h03);
      wr(1, IDX_BASE_LO, 8'h78);
      wr(2, IDX_BASE_HI, 8'h03);
      wr(2, IDX_BASE_LO, 8'hF8);
      wr(3, IDX_BASE_HI, 8'h02);
      wr(3, IDX_BASE_LO, 8'hF8);
      wr(3, IDX_BASE2_HI, 8'h02);
      wr(3, IDX_BASE2_LO, 8'h80);
      for (int g = 0; g < 4; g++) wr(g, IDX_ACTIVATE, 8'h01);
      for (int k = 0; k < 13; k++) begin
         if (decT[k][35:32] != 4'hF) begin
            wr(decT[k][33:32], IDX_BASE_HI, {4'h0, decT[k][31:28]});
            wr(decT[k][33:32], IDX_BASE_LO, decT[k][27:20]);
         end
         @(posedge clk_sys);
         hostReq <= 1'b1;
         hostRd <= k[0];
         hostAddr <= decT[k][19:8];
         repeat (5) @(posedge clk_sys);
         #1 chk("fnSel", {8'h0, fnSel}, {8'h0, decT[k][7:0]});
         hostReq <= 1'b0;
      end
      for (int i = 0; i < 80; i++) begin
         r = rnd();
         f = int'(r[1:0]);
         act = r[2];
         lv = r[6:3];
         md = r[8:7];
         ds = r[11:9];
         for (int g = 0; g < 4; g++) begin
            wr(g, IDX_ACTIVATE, {7'h0, g == f && act});
            wr(g, IDX_MODE, {6'h0, md});
         end
         wr(f, IDX_IRQ_SEL, {4'h0, lv});
         wr(f, IDX_DMA_SEL, {5'h0, ds});
         r = rnd();
         loc = r[19:0];
         @(posedge clk_sys);
         fnLocal <= loc;
         dackDelay <= r[21:20];
         fnIrqReq <= r[25:22];
         fnDrqReq <= r[29:26];
         repeat (12) @(posedge clk_sys);
         #1 e = act && lvl_ok(lv, md) && irq_en(f, loc);
         chk("irqOe", irqOe, {15'h0, e} << lv);
         chk("irqOut", irqOut & irqOe, {15'h0, e && r[22+f]} << lv);
         e = act && ds inside {3'd1, 3'd2, 3'd3} && DMA_CAPABLE[f] && drq_en(f, loc);
         chk("drqOe", {12'h0, drqOe}, e ? 16'h0001 << ds : 16'h0000);
         chk("drqOut", {12'h0, drqOut & drqOe}, {15'h0, e && r[26+f]} << ds);
         chk("fnDack", {15'h0, fnDack[f]}, {15'h0, e && r[26+f]});
      end
      for (int g = 0; g < 4; g++) begin
         wr(g, IDX_ACTIVATE, {7'h0, g == 0 || g == 2});
         wr(g, IDX_IRQ_SEL, 8'h05);
         wr(g, IDX_MODE, 8'h00);
      end
      loc = '0;
      loc.floppyDmaGate = 1'b1;
      loc.uart1IrqEnable = 4'h1;
      loc.uart1AuxOutGate = 1'b1;
      @(posedge clk_sys);
      fnLocal <= loc;
      fnIrqReq <= 4'b0100;
      repeat (4) @(posedge clk_sys);
      #1 chk("irqOe", irqOe, 16'h0020);
      chk("irqOut", irqOut & irqOe, 16'h0000);
      @(posedge clk_sys);
      fnIrqReq <= 4'b0001;
      repeat (4) @(posedge clk_sys);
      #1 chk("irqOut", irqOut & irqOe, 16'h0020);
      // mid-run reset must drop selects and pins again
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(2, IDX_IRQ_SEL, RST_IRQ_SEL);
      chk("irqOe", irqOe, 16'h0000);
      chk("fnActive", {12'h0, fnActive}, 16'h0000);
      final_report();
   end
endmodule : logical_device_irq_dma_routing_tb_top
